// ==== verilog/rsseq_pkg.sv ====
package rsseq_pkg;
    // register map
    localparam logic [7:0] ADDR_PROGRAM_FLAGS = 8'h86;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h90;
    localparam logic [7:0] ADDR_INT_MASK = 8'h91;
    localparam logic [7:0] ADDR_CONFIG = 8'h92;
    // program_flags field positions
    localparam int FLAG_CAUSE_UPPER = 7;
    localparam int FLAG_CAUSE_LOWER = 6;
    localparam int FLAG_LV_HIGH = 5;
    localparam int FLAG_LV_MID = 4;
    // config field positions
    localparam int CFG_PIN_EN = 0;
    localparam int CFG_XTAL = 1;
    localparam int CFG_LVD_MID_RST = 2;
    // reset-cause encodings {upper, lower}
    localparam logic [1:0] CAUSE_WATCHDOG = 2'h0;
    localparam logic [1:0] CAUSE_POWER = 2'h2;
    localparam logic [1:0] CAUSE_PIN = 2'h3;
    // reset values
    localparam logic [7:0] CONFIG_RESET = 8'h01;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // timing: stable-power wait and oscillator warm-up
    localparam int CLK_HZ = 20_000_000;
    localparam int POWER_STABLE_US = 100;
    localparam int RC_WARMUP_US = 32;
    localparam int XTAL_WARMUP_US = 1600;
    localparam int POWER_STABLE_CYC = (POWER_STABLE_US * (CLK_HZ / 1_000_000));
    localparam int RC_WARMUP_CYC = (RC_WARMUP_US * (CLK_HZ / 1_000_000));
    localparam int XTAL_WARMUP_CYC = (XTAL_WARMUP_US * (CLK_HZ / 1_000_000));
    localparam int CNT_W = 16;
    // interrupt status bits
    localparam int EV_RESET_DONE = 0;
    localparam int EV_LV_MID = 1;
    localparam int EV_LV_HIGH = 2;

    typedef enum {
        RSQ_POWER_UP,
        RSQ_PIN_CHECK,
        RSQ_INIT,
        RSQ_WARMUP,
        RSQ_RUN
    } rsseq_state_t;

    // reset source inputs grouped
    typedef struct packed {
        logic power_on;
        logic watchdog_ovf;
        logic brown_out;
        logic pin_n;
    } rsseq_src_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsseq_bus_t;
endpackage

// ==== verilog/rsseq_sync_rel.sv ====
`timescale 1ns/1ps
`default_nettype none
// stretches the merged reset request and releases it in clock step
module rsseq_sync_rel (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    output logic o_req
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } rsseq_sr_t;
    rsseq_sr_t s_r, s_nxt;
    // assert at once, release after two clean cycles
    always_comb begin
        s_nxt = s_r;
        s_nxt.stage1 = i_req;
        s_nxt.stage2 = s_r.stage1 | i_req;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_r <= '{stage1: 1'b1, stage2: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign o_req = s_r.stage2 | i_req;
endmodule
`default_nettype wire

// ==== verilog/rsseq_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// loadable down counter, done pulses once count reaches zero
module rsseq_timer #(
    parameter int CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [CNT_W-1:0] i_count,
    output logic o_done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } rsseq_tm_t;
    rsseq_tm_t t_r, t_nxt;
    initial begin
        if (CNT_W < 2) $error("counter width too small");
    end
    // counting
    always_comb begin
        t_nxt = t_r;
        t_nxt.done = 1'b0;
        if (i_load) begin
            t_nxt.cnt = i_count;
            t_nxt.busy = 1'b1;
        end else if (t_r.busy) begin
            if (t_r.cnt <= CNT_W'(1)) begin
                t_nxt.busy = 1'b0;
                t_nxt.done = 1'b1;
                t_nxt.cnt = '0;
            end else begin
                t_nxt.cnt = t_r.cnt - CNT_W'(1);
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end
    assign o_done = t_r.done;
endmodule
`default_nettype wire

// ==== verilog/rsseq_top.sv ====
// Functional notes
// - any active source halts execution, clears program counter, holds registers initial (code resets only the arith bits)
// - after sequence completes, fetching begins at program address zero
// - sources: power-on, watchdog, brown-out, pin only when pin reset enabled
// - two cause flags in program_flags bits 7:6, software readable and writable
// - cause code 00 watchdog, 01 reserved, 10 power or low-volt, 11 pin
// - power-on: wait for supply stable before later reset steps
// - pin enabled: stay in reset while pin is not high
// - after pin check initialise all registers, then oscillator warm-up (code clears only the arith bits)
// - wait for oscillator running before allowing execution
// - watchdog overflow enters reset, then init, warm-up, run from zero
// - after watchdog reset resume normal mode, not low power
// - warm-up short for rc oscillator, longer for crystal
// - reset pin is active low
// - lowest detector level always resets on power-on and brown-out
// - any low-voltage reset clears both low-voltage flags
`timescale 1ns/1ps
`default_nettype none
module rsseq_top
    import rsseq_pkg::*;
#(
    parameter int POWER_CYC = POWER_STABLE_CYC,
    parameter int RC_CYC = RC_WARMUP_CYC,
    parameter int XTAL_CYC = XTAL_WARMUP_CYC
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire rsseq_pkg::rsseq_src_t I_SRC,
    input wire logic I_LV_MID,
    input wire logic I_LV_HIGH,
    input wire logic I_OSC_READY,
    input wire rsseq_pkg::rsseq_bus_t I_BUS,
    output logic [7:0] O_RDATA,
    output logic O_SYS_RST,
    output logic O_RUN,
    output logic O_PC_CLEAR,
    output logic O_NORMAL_MODE,
    output logic O_IRQ
);
    import rsseq_pkg::*;

    initial begin
        if (POWER_CYC < 1 || POWER_CYC >= (1 << CNT_W)) $error("bad power wait");
        if (RC_CYC < 1 || RC_CYC >= (1 << CNT_W)) $error("bad rc warm-up");
        if (XTAL_CYC < 1 || XTAL_CYC >= (1 << CNT_W)) $error("bad crystal warm-up");
    end

    typedef struct packed {
        rsseq_state_t state;
        logic [1:0] cause;
        logic lv_mid;
        logic lv_high;
        logic [3:0] arith;
        logic [7:0] cfg;
        logic [7:0] mask;
        logic [7:0] status;
        logic [7:0] rdata;
        logic sys_rst;
        logic run;
        logic irq;
        logic timer_busy;
    } rsseq_st_t;
    rsseq_st_t st_r, st_nxt;

    logic raw_req;
    logic sync_req;
    logic pin_active;
    logic tm_load;
    logic [CNT_W-1:0] tm_count;
    logic tm_done;
    logic lv_event;
    logic [7:0] flags_view;
    logic [7:0] ev_set;

    // pin is active low and only counts when enabled
    assign pin_active = st_r.cfg[CFG_PIN_EN] & ~I_SRC.pin_n;
    // lowest detector level folded into power_on / brown_out always
    assign lv_event = I_SRC.power_on | I_SRC.brown_out;
    // OR of every enabled source
    assign raw_req = lv_event | I_SRC.watchdog_ovf | pin_active;

    rsseq_sync_rel u_sync (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_req(raw_req),
        .o_req(sync_req)
    );

    rsseq_timer #(.CNT_W(CNT_W)) u_timer (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_load(tm_load),
        .i_count(tm_count),
        .o_done(tm_done)
    );

    // program_flags view
    assign flags_view = {st_r.cause, st_r.lv_high, st_r.lv_mid, 1'b0, st_r.arith[2:0]};

    // sequencer, flags and register port
    always_comb begin
        st_nxt = st_r;
        tm_load = 1'b0;
        tm_count = '0;
        ev_set = '0;
        st_nxt.rdata = 8'h00;
        case (st_r.state)
            RSQ_POWER_UP: begin
                // supply stable wait before anything else
                if (!st_r.timer_busy) begin
                    tm_load = 1'b1;
                    tm_count = CNT_W'(POWER_CYC);
                    st_nxt.timer_busy = 1'b1;
                end else if (tm_done) begin
                    st_nxt.timer_busy = 1'b0;
                    st_nxt.state = RSQ_PIN_CHECK;
                end
            end
            RSQ_PIN_CHECK: begin
                // hold while pin enabled and not high
                if (!pin_active) begin
                    st_nxt.state = RSQ_INIT;
                end
            end
            RSQ_INIT: begin
                // initial register values, then warm-up
                st_nxt.arith = '0;
                st_nxt.state = RSQ_WARMUP;
                tm_load = 1'b1;
                tm_count = st_r.cfg[CFG_XTAL] ? CNT_W'(XTAL_CYC) : CNT_W'(RC_CYC);
                st_nxt.timer_busy = 1'b1;
            end
            RSQ_WARMUP: begin
                // oscillator must be running and warm-up elapsed
                if (tm_done) begin
                    st_nxt.timer_busy = 1'b0;
                end
                if (!st_r.timer_busy && I_OSC_READY) begin
                    st_nxt.state = RSQ_RUN;
                    st_nxt.sys_rst = 1'b0;
                    st_nxt.run = 1'b1;
                    ev_set[EV_RESET_DONE] = 1'b1;
                end
            end
            RSQ_RUN: begin
                st_nxt.run = 1'b1;
            end
            default: begin
                st_nxt.state = RSQ_POWER_UP;
            end
        endcase

        // software writes in run state, reads in any state
        if (st_r.state == RSQ_RUN && I_BUS.wr) begin
            case (I_BUS.addr)
                ADDR_PROGRAM_FLAGS: begin
                    st_nxt.cause = I_BUS.wdata[FLAG_CAUSE_UPPER:FLAG_CAUSE_LOWER];
                    st_nxt.arith = {1'b0, I_BUS.wdata[2:0]};
                end
                ADDR_INT_STATUS: st_nxt.status = st_r.status & ~I_BUS.wdata;
                ADDR_INT_MASK: st_nxt.mask = I_BUS.wdata;
                ADDR_CONFIG: st_nxt.cfg = I_BUS.wdata & 8'h07;
                default: st_nxt.status = st_nxt.status;
            endcase
        end
        if (I_BUS.rd) begin
            case (I_BUS.addr)
                ADDR_PROGRAM_FLAGS: st_nxt.rdata = flags_view;
                ADDR_INT_STATUS: st_nxt.rdata = st_r.status;
                ADDR_INT_MASK: st_nxt.rdata = st_r.mask;
                ADDR_CONFIG: st_nxt.rdata = st_r.cfg;
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // low-voltage flags live only outside reset
        if (st_r.state == RSQ_RUN) begin
            if (I_LV_MID && !st_r.lv_mid) ev_set[EV_LV_MID] = 1'b1;
            if (I_LV_HIGH && !st_r.lv_high) ev_set[EV_LV_HIGH] = 1'b1;
            st_nxt.lv_mid = I_LV_MID;
            st_nxt.lv_high = I_LV_HIGH;
        end
        // set wins over write-one clear
        st_nxt.status = st_nxt.status | ev_set;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);

        // any request restarts the sequence and records its cause
        if (sync_req) begin
            st_nxt.sys_rst = 1'b1;
            st_nxt.run = 1'b0;
            st_nxt.arith = '0;
            st_nxt.timer_busy = 1'b0;
            st_nxt.state = RSQ_POWER_UP;
            if (lv_event) begin
                st_nxt.cause = CAUSE_POWER;
                st_nxt.lv_mid = 1'b0;
                st_nxt.lv_high = 1'b0;
            end else if (pin_active) begin
                st_nxt.cause = CAUSE_PIN;
                st_nxt.state = RSQ_PIN_CHECK;
            end else if (I_SRC.watchdog_ovf) begin
                st_nxt.cause = CAUSE_WATCHDOG;
                st_nxt.state = RSQ_INIT;
            end else if (st_r.state == RSQ_RUN) begin
                st_nxt.state = RSQ_INIT;
            end else begin
                st_nxt.state = st_r.state == RSQ_POWER_UP ? RSQ_POWER_UP : RSQ_INIT;
            end
        end
    end

    // state register
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            st_r <= '0;
            st_r.state <= RSQ_POWER_UP;
            st_r.cause <= CAUSE_POWER;
            st_r.cfg <= CONFIG_RESET;
            st_r.mask <= MASK_RESET;
            st_r.sys_rst <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_RDATA = st_r.rdata;
    assign O_SYS_RST = st_r.sys_rst;
    assign O_RUN = st_r.run;
    assign O_PC_CLEAR = st_r.sys_rst;
    assign O_NORMAL_MODE = st_r.run;
    assign O_IRQ = st_r.irq;
endmodule
`default_nettype wire

// ==== sim/rsseq_top_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches reset outputs and the register port
module rsseq_top_monitor
    import rsseq_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire rsseq_pkg::rsseq_src_t I_SRC,
    input wire logic I_OSC_READY,
    input wire rsseq_pkg::rsseq_bus_t I_BUS,
    input wire logic [7:0] O_RDATA,
    input wire logic O_SYS_RST,
    input wire logic O_RUN,
    input wire logic O_PC_CLEAR,
    input wire logic O_NORMAL_MODE
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    // sources that always count
    wire logic src_any = I_SRC.power_on | I_SRC.watchdog_ovf | I_SRC.brown_out;
    property p_halt; src_any |=> O_SYS_RST && !O_RUN; endproperty
    a_halt: assert property (p_halt) else $error("no halt on source");
    property p_pc; O_PC_CLEAR == O_SYS_RST; endproperty
    a_pc: assert property (p_pc) else $error("pc clear differs");
    property p_mode; O_NORMAL_MODE == O_RUN; endproperty
    a_mode: assert property (p_mode) else $error("mode differs from run");
    property p_excl; !(O_RUN && O_SYS_RST); endproperty
    a_excl: assert property (p_excl) else $error("run during reset");
    property p_osc; $rose(O_RUN) |-> $past(I_OSC_READY); endproperty
    a_osc: assert property (p_osc) else $error("run before oscillator");
    property p_min; $rose(O_SYS_RST) |-> O_SYS_RST[*4]; endproperty
    a_min: assert property (p_min) else $error("reset too short");
    property p_keep; O_RUN && !src_any && I_SRC.pin_n && I_OSC_READY |=> O_RUN; endproperty
    a_keep: assert property (p_keep) else $error("run lost");
    property p_idle; !$past(I_BUS.rd) |-> O_RDATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    c_run: cover property ($rose(O_RUN));
    c_pin: cover property (O_SYS_RST && !I_SRC.pin_n);
    c_wdt: cover property (I_SRC.watchdog_ovf ##1 O_SYS_RST);
endmodule
bind rsseq_top rsseq_top_monitor u_mon (.*);
`default_nettype wire

// ==== sim/rsseq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// far side: reset sources, reset pin and oscillator start-up
module rsseq_model
    import rsseq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_hold,
    input wire logic [3:0] i_src,
    output rsseq_pkg::rsseq_src_t o_src,
    output logic o_osc
);
    logic [3:0] cnt_r = 4'h0;
    logic rst_d_r = 1'b0;
    // pin is active low, the rest active high
    assign o_src = {i_src[3:1], !i_src[0]};
    // oscillator restarts on each reset and needs a few cycles
    always_ff @(posedge i_clk) begin
        rst_d_r <= i_sys_rst;
        if (i_hold || (i_sys_rst && !rst_d_r)) begin
            cnt_r <= 4'h3;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    assign o_osc = (cnt_r == 4'h0);
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the reset sequencer
module testbench;
    import rsseq_pkg::*;
    localparam int PWR = 20;
    localparam int RC = 3;
    localparam int XT = 9;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hold = 1'b0;
    logic lvm = 1'b0;
    logic lvh = 1'b0;
    logic [3:0] s = 4'h0;
    rsseq_bus_t bus = '0;
    rsseq_src_t src;
    logic osc, sys_rst, run, pc_clr, nmode, irq, rd_d;
    logic [7:0] rdata, w;
    logic [7:0] expq[$];
    int err_total = 0;
    int checked = 0;
    int seed = 32'hf0ff;
    int n0, n1, n2;

    always #25 clk = ~clk;
    rsseq_model u_model (.i_clk(clk), .i_sys_rst(sys_rst), .i_hold(hold), .i_src(s),
        .o_src(src), .o_osc(osc));
    rsseq_top #(.POWER_CYC(PWR), .RC_CYC(RC), .XTAL_CYC(XT)) uut (.I_SYS_CLK(clk),
        .I_RST_N(rst_n), .I_SRC(src), .I_LV_MID(lvm), .I_LV_HIGH(lvh), .I_OSC_READY(osc),
        .I_BUS(bus), .O_RDATA(rdata), .O_SYS_RST(sys_rst), .O_RUN(run), .O_PC_CLEAR(pc_clr),
        .O_NORMAL_MODE(nmode), .O_IRQ(irq));

    task automatic chk(input logic [7:0] e, input logic [7:0] a);
        checked++;
        if (a !== e) begin
            err_total++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one bus cycle, released after one edge
    task automatic op(input logic [7:0] a, input logic [7:0] d, input logic r);
        @(posedge clk);
        if (r) begin
            expq.push_back(d);
        end
        bus <= '{addr: a, wdata: d, wr: !r, rd: r};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
    endtask
    // holds source lines for len cycles
    task automatic pulse(input logic [3:0] v, input int len);
        @(posedge clk);
        s <= v;
        repeat (len) @(negedge clk);
        @(posedge clk);
        s <= 4'h0;
        @(negedge clk);
    endtask
    task automatic wait_run(output int n);
        n = 0;
        while (run !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk(8'h03, {6'h0, run, nmode});
    endtask

    // read result checker: oldest note against data after the strobe
    always @(posedge clk) rd_d <= bus.rd;
    always @(negedge clk) begin
        if (rd_d === 1'b1 && expq.size() > 0) begin
            chk(expq.pop_front(), rdata);
        end
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_run(n0);
        op(ADDR_PROGRAM_FLAGS, 8'h80, 1'b1);
        op(ADDR_CONFIG, CONFIG_RESET, 1'b1);
        op(8'ha0, 8'h00, 1'b1);
        w = 8'($random(seed));
        op(ADDR_PROGRAM_FLAGS, w, 1'b0);
        op(ADDR_PROGRAM_FLAGS, w & 8'hc7, 1'b1);
        $display("registers done");
        op(ADDR_INT_STATUS, 8'h01, 1'b1);
        op(ADDR_INT_MASK, 8'h02, 1'b0);
        chk(8'h00, {7'h0, irq});
        @(posedge clk);
        lvm <= 1'b1;
        repeat (3) @(negedge clk);
        chk(8'h01, {7'h0, irq});
        op(ADDR_INT_STATUS, 8'h02, 1'b0);
        repeat (2) @(negedge clk);
        chk(8'h00, {7'h0, irq});
        op(ADDR_INT_STATUS, 8'h01, 1'b1);
        @(posedge clk);
        lvm <= 1'b0;
        $display("interrupt done");
        pulse(4'h4, 1);
        wait_run(n1);
        op(ADDR_PROGRAM_FLAGS, 8'h00, 1'b1);
        op(ADDR_CONFIG, 8'h03, 1'b0);
        pulse(4'h4, 1);
        wait_run(n2);
        chk(8'(XT - RC), 8'(n2 - n1));
        op(ADDR_CONFIG, CONFIG_RESET, 1'b0);
        $display("watchdog done");
        @(posedge clk);
        hold <= 1'b1;
        pulse(4'h4, 1);
        repeat (40) @(negedge clk);
        chk(8'h00, {7'h0, run});
        @(posedge clk);
        hold <= 1'b0;
        wait_run(n0);
        $display("oscillator done");
        @(posedge clk);
        s <= 4'h1;
        repeat (30) @(negedge clk);
        chk(8'h01, {7'h0, sys_rst});
        op(ADDR_PROGRAM_FLAGS, 8'hff, 1'b0);
        pulse(4'h0, 1);
        wait_run(n0);
        op(ADDR_PROGRAM_FLAGS, 8'hc0, 1'b1);
        op(ADDR_CONFIG, 8'h00, 1'b0);
        pulse(4'h1, 10);
        chk(8'h01, {7'h0, run});
        op(ADDR_CONFIG, CONFIG_RESET, 1'b0);
        $display("pin done");
        pulse(4'h8, 3);
        wait_run(n2);
        chk(8'h01, {7'h0, n2 >= n1 + PWR});
        op(ADDR_PROGRAM_FLAGS, 8'h80, 1'b1);
        pulse(4'h2, 3);
        wait_run(n2);
        op(ADDR_PROGRAM_FLAGS, 8'h80, 1'b1);
        $display("power done");
        results();
    end

    // watchdog against a hang
    initial begin
        #(50 * 30000);
        err_total++;
        results();
    end
endmodule
`default_nettype wire
